// file: dog_bus_pkg.sv
// Shared constants for the watchdog setup and bus transceiver mode registers
package dog_bus_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [6:0] watchdog_setup_addr = 7'h03;
   localparam logic [6:0] bus_transceiver_mode_addr = 7'h04;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int checksum_bit = 15;
   localparam int stop_dog_off_first_bit = 6;
   localparam int dog_type_select_bit = 5;
   localparam int dog_start_on_bus_wake_bit = 4;
   localparam int selective_wake_bit = 2;

   // ----------------------------------------------------------------
   // Writable masks and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] watchdog_setup_mask = 16'h8077;
   localparam logic [15:0] bus_transceiver_mode_mask = 16'h0007;
   localparam logic [15:0] watchdog_setup_reset = 16'h0014;
   localparam logic [15:0] watchdog_setup_restart = 16'h0004;
   localparam logic [15:0] bus_transceiver_mode_reset = 16'h0020;
   localparam logic [15:0] bus_fail_safe_value = 16'h0009;
   localparam logic [2:0] can_wake_soft_dev = 3'h1;

   // ----------------------------------------------------------------
   // Transceiver mode (low two bits of the mode field)
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      can_off = 2'h0,
      can_wake = 2'h1,
      can_receive = 2'h2,
      can_normal = 2'h3
   } can_mode_t;

   typedef enum logic [1:0] {
      dog_timeout = 2'h0,
      dog_window = 2'h1,
      dog_stop_off = 2'h2
   } dog_state_t;

endpackage

// file: field_reg.sv
// One writable field with a software write and a hardware update path
`timescale 1ns/1ps
module field_reg #(
   parameter int width = 3,
   parameter logic [width-1:0] reset_value = '0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic soft_load,
   input wire logic [width-1:0] soft_value,
   input wire logic sw_write,
   input wire logic [width-1:0] sw_value,
   input wire logic hw_write,
   input wire logic [width-1:0] hw_value,
   output logic [width-1:0] value
);
   // Hardware update wins over a same-cycle software write
   always_ff @(posedge clk) begin
      if (!nrst) begin
         value <= reset_value;
      end else if (soft_load) begin
         value <= soft_value;
      end else if (hw_write) begin
         value <= hw_value;
      end else if (sw_write) begin
         value <= sw_value;
      end
   end
endmodule // field_reg

// file: dog_mode_decode.sv
// Decodes the watchdog setup fields into a period index and a run state
`timescale 1ns/1ps
module dog_mode_decode
(
   input wire logic [2:0] period_code,
   input wire logic window_sel,
   input wire logic stop_mode,
   input wire logic stop_off,
   output logic [3:0] period_index,
   output dog_bus_pkg::dog_state_t state
);
   import dog_bus_pkg::*;

   always_comb begin
      // 110 is not a listed period; treat it like the next shorter one (101)
      unique case (period_code)
         3'h0: period_index = 4'h0;
         3'h1: period_index = 4'h1;
         3'h2: period_index = 4'h2;
         3'h3: period_index = 4'h3;
         3'h4: period_index = 4'h4;
         3'h5: period_index = 4'h5;
         3'h6: period_index = 4'h5;
         3'h7: period_index = 4'h7;
      endcase
      if (stop_mode && stop_off) begin
         state = dog_stop_off;
      end else if (window_sel) begin
         state = dog_window;
      end else begin
         state = dog_timeout;
      end
   end
endmodule // dog_mode_decode

// file: watchdog_and_can_mode_config.sv
// Watchdog setup and bus transceiver mode register bank
// Behaviour
// RULE1: Second stop watchdog-off bit clears on Stop to Normal transition.
// RULE2: Bit 15 of watchdog setup is read-write checksum bit.
// RULE3: Watchdog setup bits 14:7 and 3 read as zero.
// RULE4: Bit 6 requests watchdog off in Stop; device may update it.
// RULE5: Bit 5 chooses time-out (0) or window (1) watchdog.
// RULE6: Bit 4 set starts watchdog after CAN wake in Stop.
// RULE7: Bits 2:0 select the watchdog period code.
// RULE8: Restart reloads watchdog setup to 0x0004, bit 4 kept.
// RULE9: Mode codes 000..011 are off, wake, receive, normal, no selective.
// RULE10: Codes 100..111 are the same modes with selective wake.
// RULE11: Device never alters the selective wake bit; here fail-safe entry clears it.
// RULE12: Sleep entry without system error turns normal into wake capable.
// RULE13: Receive only goes wake on Sleep, stays on Stop.
// RULE14: Wake capable or off stays unchanged on Sleep or Stop.
// RULE15: Software selects receive only before requesting Stop Mode.
// RULE16: Fail-Safe entry forces mode field low bits to 01001.
// RULE17: Restart loads low mode bits from the cause input.
// RULE18: Software development mode resets mode field to 001.
// RULE19: Second stop watchdog-off bit sits at hardware setup bit 2.
// RULE20: Read data after a write shows the value before the write.
// RULE21: Writes to reserved bits are dropped; they read zero.
`timescale 1ns/1ps
module watchdog_and_can_mode_config
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic access_valid,
   input wire logic access_write,
   input wire logic [6:0] access_addr,
   input wire logic [15:0] access_wdata,
   input wire logic soft_reset,
   input wire logic soft_dev_mode,
   input wire logic restart,
   input wire logic [1:0] restart_can_mode,
   input wire logic fail_safe_entry,
   input wire logic sleep_entry,
   input wire logic stop_entry,
   input wire logic stop_to_normal,
   input wire logic stop_mode,
   input wire logic system_error_flag,
   input wire logic hw_stop_off_first,
   input wire logic hw_stop_off_first_set,
   input wire logic stop_off_second_write,
   input wire logic stop_off_second_wdata,
   output logic [15:0] access_rdata,
   output logic access_hit,
   output logic [15:0] watchdog_setup,
   output logic [15:0] bus_transceiver_mode,
   output logic stop_dog_off_second,
   output logic [3:0] dog_period_index,
   output dog_bus_pkg::dog_state_t dog_state,
   output logic dog_start_on_bus_wake
);
   import dog_bus_pkg::*;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic sel_dog;
   logic sel_bus;
   logic wr_dog;
   logic wr_bus;
   logic [15:0] dog_w;
   logic reset_load;
   logic [15:0] next_dog;
   logic [2:0] mode;
   logic [2:0] next_mode;
   logic mode_hw;
   logic [3:0] idx;
   dog_state_t st;

   assign sel_dog = access_addr == watchdog_setup_addr;
   assign sel_bus = access_addr == bus_transceiver_mode_addr;
   assign wr_dog = access_valid && access_write && sel_dog;
   assign wr_bus = access_valid && access_write && sel_bus;
   assign dog_w = access_wdata & watchdog_setup_mask; // [RULE21] [RULE3]
   assign reset_load = soft_reset;

   // ----------------------------------------------------------------
   // Watchdog setup register
   // ----------------------------------------------------------------
   always_comb begin
      next_dog = watchdog_setup;
      if (reset_load) begin
         next_dog = watchdog_setup_reset;
      end else if (restart) begin
         // Bit 4 undefined on restart; holding it is the cheap choice
         next_dog = watchdog_setup_restart; // [RULE8]
         next_dog[dog_start_on_bus_wake_bit] =
            watchdog_setup[dog_start_on_bus_wake_bit];
      end else begin
         if (wr_dog) begin
            next_dog = dog_w; // [RULE2] [RULE5] [RULE6] [RULE7]
         end
         if (hw_stop_off_first_set) begin
            next_dog[stop_dog_off_first_bit] = hw_stop_off_first; // [RULE4]
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         watchdog_setup <= watchdog_setup_reset;
      end else begin
         watchdog_setup <= next_dog;
      end
   end

   // ----------------------------------------------------------------
   // Second stop watchdog-off bit (hardware setup bit 2)
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         stop_dog_off_second <= 1'b0;
      end else if (reset_load || restart || stop_to_normal) begin
         stop_dog_off_second <= 1'b0; // [RULE1]
      end else if (stop_off_second_write) begin
         stop_dog_off_second <= stop_off_second_wdata; // [RULE19]
      end
   end

   // ----------------------------------------------------------------
   // Bus transceiver mode field
   // ----------------------------------------------------------------
   always_comb begin
      mode = bus_transceiver_mode[2:0];
      next_mode = mode;
      mode_hw = 1'b1;
      // Selective wake kept; only the fail-safe value overrides it
      if (fail_safe_entry) begin
         next_mode = bus_fail_safe_value[2:0]; // [RULE16]
      end else if (restart) begin
         next_mode = {mode[2], restart_can_mode}; // [RULE17] [RULE11]
      end else if (sleep_entry && !system_error_flag &&
                   mode[1:0] == can_normal) begin
         next_mode = {mode[2], can_wake}; // [RULE12] [RULE11]
      end else if (sleep_entry && mode[1:0] == can_receive) begin
         next_mode = {mode[2], can_wake}; // [RULE13]
      end else begin
         mode_hw = 1'b0; // [RULE14] [RULE15]
      end
   end

   logic [2:0] mode_q;
   field_reg #(
      .width(3),
      .reset_value(bus_transceiver_mode_reset[2:0])
   ) u_mode (
      .clk(clk),
      .nrst(nrst),
      .soft_load(reset_load),
      .soft_value(soft_dev_mode ? can_wake_soft_dev :
                  bus_transceiver_mode_reset[2:0]), // [RULE18]
      .sw_write(wr_bus),
      .sw_value(access_wdata[2:0]), // [RULE9] [RULE10] [RULE21]
      .hw_write(mode_hw),
      .hw_value(next_mode),
      .value(mode_q)
   );

   // Upper reset bit (0x20) is a reserved-read position: kept at reset only
   logic bit5;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bit5 <= bus_transceiver_mode_reset[5];
      end else if (reset_load) begin
         bit5 <= bus_transceiver_mode_reset[5];
      end else if (wr_bus || mode_hw) begin
         bit5 <= 1'b0;
      end
   end

   // Fail-safe shows bit 3 set; reserved again after the next change
   logic fail_safe_mark;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         fail_safe_mark <= 1'b0;
      end else if (reset_load) begin
         fail_safe_mark <= 1'b0;
      end else if (fail_safe_entry) begin
         fail_safe_mark <= bus_fail_safe_value[3]; // [RULE16]
      end else if (wr_bus || mode_hw) begin
         fail_safe_mark <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         bus_transceiver_mode <= bus_transceiver_mode_reset;
      end else begin
         bus_transceiver_mode <=
            {10'h000, bit5, 1'b0, fail_safe_mark, mode_q}; // [RULE16]
      end
   end

   // ----------------------------------------------------------------
   // Read port: shows contents before this cycle's write
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         access_rdata <= 16'h0000;
         access_hit <= 1'b0;
      end else begin
         access_hit <= access_valid && (sel_dog || sel_bus);
         if (access_valid && sel_dog) begin
            access_rdata <= watchdog_setup; // [RULE20]
         end else if (access_valid && sel_bus) begin
            access_rdata <= bus_transceiver_mode; // [RULE20]
         end else begin
            access_rdata <= 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Watchdog decode outputs
   // ----------------------------------------------------------------
   dog_mode_decode u_dec (
      .period_code(watchdog_setup[2:0]),
      .window_sel(watchdog_setup[dog_type_select_bit]),
      .stop_mode(stop_mode),
      .stop_off(watchdog_setup[stop_dog_off_first_bit] |
                stop_dog_off_second),
      .period_index(idx),
      .state(st)
   );

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dog_period_index <= 4'h0;
         dog_state <= dog_timeout;
         dog_start_on_bus_wake <= 1'b0;
      end else begin
         dog_period_index <= idx; // [RULE7]
         dog_state <= st; // [RULE5] [RULE4]
         dog_start_on_bus_wake <=
            watchdog_setup[dog_start_on_bus_wake_bit]; // [RULE6]
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_rsv_zero;
      @(posedge clk) disable iff (!nrst)
         (watchdog_setup & ~watchdog_setup_mask) == 16'h0000;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) // [RULE3]
      else $error("reserved watchdog bits nonzero");

   property p_stop_clear;
      @(posedge clk) disable iff (!nrst)
         stop_to_normal |=> !stop_dog_off_second;
   endproperty
   a_stop_clear: assert property (p_stop_clear) // [RULE1]
      else $error("second stop bit not cleared");

   property p_swk_kept;
      @(posedge clk) disable iff (!nrst)
         !wr_bus && !reset_load && !fail_safe_entry
         |=> mode_q[2] == $past(mode_q[2]);
   endproperty
   a_swk_kept: assert property (p_swk_kept) // [RULE11]
      else $error("selective wake changed by device");

   property p_sleep_norm;
      @(posedge clk) disable iff (!nrst)
         sleep_entry && !system_error_flag && !fail_safe_entry &&
         !restart && !reset_load && mode_q[1:0] == 2'h3
         |=> mode_q[1:0] == 2'h1;
   endproperty
   a_sleep_norm: assert property (p_sleep_norm) // [RULE12]
      else $error("normal not moved to wake on sleep");

   property p_stop_rx;
      @(posedge clk) disable iff (!nrst)
         stop_entry && !sleep_entry && !fail_safe_entry && !restart &&
         !reset_load && !wr_bus && mode_q[1:0] == 2'h2
         |=> mode_q[1:0] == 2'h2;
   endproperty
   a_stop_rx: assert property (p_stop_rx) // [RULE13]
      else $error("receive only lost on stop");

   property p_fail;
      @(posedge clk) disable iff (!nrst)
         fail_safe_entry && !reset_load |=> mode_q == 3'h1 ##1
         bus_transceiver_mode[4:0] == bus_fail_safe_value[4:0];
   endproperty
   a_fail: assert property (p_fail) // [RULE16]
      else $error("fail-safe mode value wrong");

   property p_restart;
      @(posedge clk) disable iff (!nrst)
         restart && !reset_load |=>
         (watchdog_setup & 16'hffef) == 16'h0004;
   endproperty
   a_restart: assert property (p_restart) // [RULE8]
      else $error("restart value wrong");

   property p_old_read;
      @(posedge clk) disable iff (!nrst)
         wr_dog ##1 1 |-> access_rdata == $past(watchdog_setup);
   endproperty
   a_old_read: assert property (p_old_read) // [RULE20]
      else $error("read shows new value");

   property p_swdev;
      @(posedge clk) disable iff (!nrst)
         reset_load && soft_dev_mode |=> mode_q == 3'h1;
   endproperty
   a_swdev: assert property (p_swdev) // [RULE18]
      else $error("development reset value wrong");

   c_sleep: cover property (@(posedge clk) sleep_entry && mode_q == 3'h3);
   c_fail: cover property (@(posedge clk) fail_safe_entry);
   c_restart: cover property (@(posedge clk) restart);
   c_write: cover property (@(posedge clk) wr_dog);

endmodule // watchdog_and_can_mode_config

// file: watchdog_and_can_mode_config_test.sv
// Self-checking bench for the watchdog setup and bus mode registers
`timescale 1ns/1ps
module watchdog_and_can_mode_config_test;
   import dog_bus_pkg::*;
   logic clk, nrst, access_valid, access_write, soft_reset, soft_dev_mode;
   logic restart, fail_safe_entry, sleep_entry, stop_entry, stop_to_normal;
   logic stop_mode, system_error_flag, hw_stop_off_first;
   logic hw_stop_off_first_set, stop_off_second_write, stop_off_second_wdata;
   logic [6:0] access_addr;
   logic [15:0] access_wdata, access_rdata, watchdog_setup;
   logic [15:0] bus_transceiver_mode, wd, bm, d;
   logic [1:0] restart_can_mode;
   logic access_hit, stop_dog_off_second, dog_start_on_bus_wake;
   logic [3:0] dog_period_index;
   dog_state_t dog_state;
   int n_fail = 0;
   int checks = 0;
   int cycles = 0;
   int i;
   integer seed = 32'h15c7;

   watchdog_and_can_mode_config u_dut (
      .clk(clk), .nrst(nrst), .access_valid(access_valid),
      .access_write(access_write), .access_addr(access_addr),
      .access_wdata(access_wdata), .soft_reset(soft_reset),
      .soft_dev_mode(soft_dev_mode), .restart(restart),
      .restart_can_mode(restart_can_mode),
      .fail_safe_entry(fail_safe_entry), .sleep_entry(sleep_entry),
      .stop_entry(stop_entry), .stop_to_normal(stop_to_normal),
      .stop_mode(stop_mode), .system_error_flag(system_error_flag),
      .hw_stop_off_first(hw_stop_off_first),
      .hw_stop_off_first_set(hw_stop_off_first_set),
      .stop_off_second_write(stop_off_second_write),
      .stop_off_second_wdata(stop_off_second_wdata),
      .access_rdata(access_rdata), .access_hit(access_hit),
      .watchdog_setup(watchdog_setup),
      .bus_transceiver_mode(bus_transceiver_mode),
      .stop_dog_off_second(stop_dog_off_second),
      .dog_period_index(dog_period_index), .dog_state(dog_state),
      .dog_start_on_bus_wake(dog_start_on_bus_wake)
   );

   // ------------------------------
   // Clock, timeout, helpers
   // ------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Generous ceiling; the sequence needs well under 1000 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail = n_fail + 1;
         $display("BAD %0t timeout", $time);
         summarize();
      end
   end

   task automatic summarize();
      if (n_fail == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD %0t word %h want %h", $time, got, exp);
      end
   endtask

   task automatic cmp1(input logic got, input logic exp);
      checks = checks + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD %0t flag %b want %b", $time, got, exp);
      end
   endtask

   // One access; rdata is checked just after the edge that takes it
   task automatic acc(input logic wr, input logic [6:0] a,
                      input logic [15:0] v);
      logic hit;
      logic [15:0] old;
      hit = (a == watchdog_setup_addr) || (a == bus_transceiver_mode_addr);
      old = (a == watchdog_setup_addr) ? wd : (hit ? bm : 16'h0000);
      @(posedge clk);
      #1;
      access_valid = 1'b1;
      access_write = wr;
      access_addr = a;
      access_wdata = v;
      @(posedge clk);
      #1;
      access_valid = 1'b0;
      cmp16(access_rdata, old);
      cmp1(access_hit, hit);
      if (wr && a == watchdog_setup_addr) wd = v & watchdog_setup_mask;
      if (wr && a == bus_transceiver_mode_addr) begin
         bm = v & bus_transceiver_mode_mask;
      end
   endtask

   // Pulse one device event, then let the lagging outputs settle
   task automatic ev(input int k);
      @(posedge clk);
      #1;
      case (k)
         0: restart = 1'b1;
         1: fail_safe_entry = 1'b1;
         2: sleep_entry = 1'b1;
         3: stop_entry = 1'b1;
         4: stop_to_normal = 1'b1;
         5: soft_reset = 1'b1;
         6: hw_stop_off_first_set = 1'b1;
         default: stop_off_second_write = 1'b1;
      endcase
      @(posedge clk);
      #1;
      {restart, fail_safe_entry, sleep_entry, stop_entry} = 4'h0;
      {stop_to_normal, soft_reset, hw_stop_off_first_set} = 3'h0;
      stop_off_second_write = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic look();
      repeat (2) @(posedge clk);
      #1;
      cmp16(watchdog_setup, wd);
      cmp16(bus_transceiver_mode, bm);
   endtask

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      {nrst, access_valid, access_write, soft_reset, soft_dev_mode} = 5'h00;
      {restart, fail_safe_entry, sleep_entry, stop_entry} = 4'h0;
      {stop_to_normal, stop_mode, system_error_flag} = 3'h0;
      {hw_stop_off_first, hw_stop_off_first_set} = 2'h0;
      {stop_off_second_write, stop_off_second_wdata} = 2'h0;
      access_addr = 7'h00;
      access_wdata = 16'h0000;
      restart_can_mode = 2'h0;
      wd = watchdog_setup_reset;
      bm = bus_transceiver_mode_reset;
      repeat (6) @(posedge clk);
      #1;
      nrst = 1'b1;
      look();
      cmp1(stop_dog_off_second, 1'b0);
      acc(1'b0, bus_transceiver_mode_addr, 16'h0000);
      acc(1'b1, watchdog_setup_addr, 16'hffff);
      acc(1'b0, watchdog_setup_addr, 16'h0000);
      acc(1'b0, 7'h05, 16'h0000);
      acc(1'b1, 7'h7f, 16'hffff);
      for (i = 0; i < 40; i++) begin
         d = $random(seed);
         acc(1'b1, i[0] ? watchdog_setup_addr : bus_transceiver_mode_addr, d);
         repeat (2) @(posedge clk);
         #1;
         cmp1(dog_start_on_bus_wake, wd[4]);
         cmp1(dog_state === (wd[5] ? dog_window : dog_timeout), 1'b1);
         d = (wd[2:0] == 3'h5 || wd[2:0] == 3'h6) ? 16'h0005 :
             {13'h0, wd[2:0]};
         cmp16({12'h000, dog_period_index}, d);
         look();
      end
      // Every mode code through Sleep, and Stop where defined
      for (i = 0; i < 8; i++) begin
         acc(1'b1, bus_transceiver_mode_addr, i[15:0]);
         ev(2);
         if (i[1]) bm = (bm & 16'h0004) | 16'h0001;
         look();
         if (i[1:0] != 2'h3) begin
            acc(1'b1, bus_transceiver_mode_addr, i[15:0]);
            ev(3);
            look();
         end
      end
      acc(1'b1, bus_transceiver_mode_addr, 16'h0003);
      system_error_flag = 1'b1;
      ev(2);
      look();
      system_error_flag = 1'b0;
      ev(1);
      bm = bus_fail_safe_value;
      look();
      acc(1'b1, bus_transceiver_mode_addr, 16'h0006);
      d = $random(seed);
      restart_can_mode = d[1:0];
      ev(0);
      wd = watchdog_setup_restart | (wd & 16'h0010);
      bm = (bm & 16'h0004) | {14'h0000, d[1:0]};
      look();
      hw_stop_off_first = ~wd[6];
      ev(6);
      wd[6] = hw_stop_off_first;
      look();
      stop_off_second_wdata = 1'b1;
      stop_mode = 1'b1;
      ev(7);
      cmp1(stop_dog_off_second, 1'b1);
      cmp1(dog_state === dog_stop_off, 1'b1);
      ev(4);
      stop_mode = 1'b0;
      cmp1(stop_dog_off_second, 1'b0);
      // Plain soft reset, then one in development mode
      ev(5);
      wd = watchdog_setup_reset;
      bm = bus_transceiver_mode_reset;
      look();
      soft_dev_mode = 1'b1;
      ev(5);
      bm = bus_transceiver_mode_reset | {13'h0, can_wake_soft_dev};
      look();
      cmp1(bus_transceiver_mode[2:0] === can_wake_soft_dev, 1'b1);
      summarize();
   end
endmodule // watchdog_and_can_mode_config_test
